// ### rtl/flash_cyc_if.sv
`timescale 1ns/1ps
`default_nettype none
interface flash_cyc_if;
   logic req;
   logic we;
   logic [22:0] addr;
   logic [15:0] wdata;
   logic done;
   logic [15:0] rdata;
   modport ctrl (output req, output we, output addr, output wdata, input done, input rdata);
   modport cyc (input req, input we, input addr, input wdata, output done, output rdata);
endinterface
`default_nettype wire

// ### rtl/flash_cycle.sv
`timescale 1ns/1ps
`default_nettype none
module flash_cycle
   import flash_host_pkg::*;
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // request side
   flash_cyc_if.cyc bus,
   // flash pins
   output logic [ADDR_W-1:0] o_addr,
   output logic [DQ_W-1:0] o_dq,
   output logic o_dq_oe,
   input wire logic [DQ_W-1:0] i_dq,
   output logic o_cs_n,
   output logic o_oe_n,
   output logic o_we_n
);
   typedef enum logic [1:0] {CY_IDLE = 2'h0, CY_SETUP = 2'h1, CY_STROBE = 2'h2, CY_HOLD = 2'h3} cyc_state_type;
   cyc_state_type state_q;
   logic [3:0] cnt_q;
   logic we_q;
   wire logic [3:0] strobe_len = we_q ? 4'(WE_CYC) : 4'(ACC_CYC);
   wire logic strobe_end = (state_q == CY_STROBE) && (cnt_q == strobe_len - 4'h1);

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         state_q <= CY_IDLE;
         cnt_q <= 4'h0;
         we_q <= 1'b0;
         o_addr <= '0;
         o_dq <= '0;
         o_dq_oe <= 1'b0;
         o_cs_n <= 1'b1;
         o_oe_n <= 1'b1;
         o_we_n <= 1'b1;
         bus.done <= 1'b0;
         bus.rdata <= '0;
      end
      else
      begin
         bus.done <= 1'b0;
         case (state_q)
            CY_IDLE:
            begin
               if (bus.req)
               begin
                  state_q <= CY_SETUP;
                  we_q <= bus.we;
                  o_addr <= bus.addr;
                  o_dq <= bus.wdata;
                  o_dq_oe <= bus.we;
                  o_cs_n <= 1'b0;
               end
            end
            CY_SETUP:
            begin
               state_q <= CY_STROBE;
               cnt_q <= 4'h0;
               o_we_n <= ~we_q;
               o_oe_n <= we_q;
            end
            CY_STROBE:
            begin
               cnt_q <= cnt_q + 4'h1;
               if (strobe_end)
               begin
                  // data latches at the rising write strobe; read sampled after access time
                  state_q <= CY_HOLD;
                  o_we_n <= 1'b1;
                  o_oe_n <= 1'b1;
                  if (!we_q)
                     bus.rdata <= i_dq;
               end
            end
            default:
            begin
               state_q <= CY_IDLE;
               o_cs_n <= 1'b1;
               o_dq_oe <= 1'b0;
               bus.done <= 1'b1;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ### rtl/flash_host_pkg.sv
package flash_host_pkg;
   localparam int CLK_MHZ = 40;
   localparam int ADDR_W = 23;
   localparam int DQ_W = 16;
   // bus-cycle timing, in ns
   localparam int T_WE_PULSE_NS = 50;
   localparam int T_ACCESS_NS = 120;
   localparam int WE_CYC = (T_WE_PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int ACC_CYC = (T_ACCESS_NS * CLK_MHZ + 999) / 1000;
   // command gaps, in us (the erase gap is 1.2 ms)
   localparam int T_LOCK_PROG_US = 100;
   localparam int T_PPB_ERASE_US = 1200;
   localparam int T_PW_GAP_US = 2;
   localparam int LOCK_PROG_CYC = T_LOCK_PROG_US * CLK_MHZ;
   localparam int PPB_ERASE_CYC = T_PPB_ERASE_US * CLK_MHZ;
   localparam int PW_GAP_CYC = T_PW_GAP_US * CLK_MHZ;
   localparam logic [3:0] RETRY_MAX = 4'h8;
   // unlock pattern
   localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
   localparam logic [11:0] ADDR_UNLOCK2 = 12'h2AA;
   localparam logic [7:0] DATA_UNLOCK1 = 8'hAA;
   localparam logic [7:0] DATA_UNLOCK2 = 8'h55;
   // command bytes
   localparam logic [7:0] CMD_RESET = 8'hF0;
   localparam logic [7:0] CMD_SEC_ENTRY = 8'h88;
   localparam logic [7:0] CMD_AUTOSEL = 8'h90;
   localparam logic [7:0] CMD_LOCK = 8'h60;
   localparam logic [7:0] CMD_PROG_BIT = 8'h68;
   localparam logic [7:0] CMD_BIT_VERIFY = 8'h48;
   localparam logic [7:0] CMD_PW_PROG = 8'h38;
   localparam logic [7:0] CMD_PW_VERIFY = 8'hC8;
   localparam logic [7:0] CMD_PW_UNLOCK = 8'h28;
   localparam logic [7:0] CMD_ERASE_BITS = 8'h40;
   localparam logic [7:0] CMD_LOCK_SET = 8'h78;
   localparam logic [7:0] CMD_LOCK_STATUS = 8'h58;
   localparam logic [7:0] CMD_PROGRAM = 8'hA0;
   localparam logic [7:0] CMD_ERASE = 8'h80;
   localparam logic [7:0] CMD_SECT_ERASE = 8'h30;
   // low address byte of protection bits
   localparam logic [7:0] LOW_SECURE = 8'h1A;
   localparam logic [7:0] LOW_PW_LOCK = 8'h0A;
   localparam logic [7:0] LOW_PERS_LOCK = 8'h12;
   localparam logic [7:0] LOW_PPB = 8'h02;
   // register map
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_ADDR = 8'h04;
   localparam logic [7:0] REG_DATA = 8'h08;
   localparam logic [7:0] REG_STATUS = 8'h0C;
   localparam logic [7:0] REG_PW0 = 8'h10;
   localparam int CTRL_GO_BIT = 8;
   localparam int CTRL_ABORT_BIT = 9;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_PASS_BIT = 1;
   localparam int ST_FAIL_BIT = 2;
   localparam int ST_ABORT_BIT = 3;
   localparam int ST_PROT_BIT = 4;
   localparam int ST_LOCK_BIT = 5;
   localparam int ST_RDATA_POS = 16;
   localparam int POLL_BIT = 7;

   typedef enum logic [4:0] {
      OP_RESET = 5'h00, OP_SEC_ENTRY = 5'h01, OP_SEC_EXIT = 5'h02, OP_SEC_PROT_PROG = 5'h03,
      OP_SEC_PROT_STATUS = 5'h04, OP_PW_PROG = 5'h05, OP_PW_VERIFY = 5'h06, OP_PW_UNLOCK = 5'h07,
      OP_PPB_PROG = 5'h08, OP_PPB_STATUS = 5'h09, OP_PPB_ERASE_ALL = 5'h0A, OP_LOCK_SET = 5'h0B,
      OP_LOCK_STATUS = 5'h0C, OP_DYB_WRITE = 5'h0D, OP_DYB_ERASE = 5'h0E, OP_DYB_STATUS = 5'h0F,
      OP_PWLOCK_PROG = 5'h10, OP_PWLOCK_STATUS = 5'h11, OP_PERSLOCK_PROG = 5'h12,
      OP_PERSLOCK_STATUS = 5'h13, OP_PROGRAM = 5'h14, OP_SECT_ERASE = 5'h15
   } op_type;

   typedef enum logic [2:0] {
      SK_WR = 3'h0, SK_RD = 3'h1, SK_WAIT_LOCK = 3'h2, SK_WAIT_ERASE = 3'h3,
      SK_WAIT_PW = 3'h4, SK_POLL = 3'h5, SK_END = 3'h6
   } step_kind_type;

   typedef struct packed {
      step_kind_type kind;
      logic [ADDR_W-1:0] addr;
      logic [DQ_W-1:0] data;
   } step_type;
endpackage

// ### rtl/flash_protect_host.sv
// The register offsets and the Wishbone slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module flash_protect_host
   import flash_host_pkg::*;
#(
   parameter int PPB_ERASE_WAIT = flash_host_pkg::PPB_ERASE_CYC
)
(
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_RST_N,
   // wishbone slave
   input wire logic I_WB_CYC,
   input wire logic I_WB_STB,
   input wire logic I_WB_WE,
   input wire logic [7:0] I_WB_ADR,
   input wire logic [3:0] I_WB_SEL,
   input wire logic [31:0] I_WB_DAT,
   output logic [31:0] O_WB_DAT,
   output logic O_WB_ACK,
   // flash pins
   output logic [flash_host_pkg::ADDR_W-1:0] O_FLASH_ADDR,
   output logic [flash_host_pkg::DQ_W-1:0] O_FLASH_DQ,
   output logic O_FLASH_DQ_OE,
   input wire logic [flash_host_pkg::DQ_W-1:0] I_FLASH_DQ,
   output logic O_FLASH_CS_N,
   output logic O_FLASH_OE_N,
   output logic O_FLASH_WE_N
);
   import flash_host_pkg::*;

   typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_EXEC = 2'h1, ST_BUS = 2'h2, ST_WAIT = 2'h3} state_type;

   function automatic logic [31:0] merge32(logic [31:0] old, logic [31:0] nw, logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
         if (sel[b])
            r[b*8 +: 8] = nw[b*8 +: 8];
      return r;
   endfunction

   function automatic logic [7:0] cmd_of(op_type op);
      case (op)
         OP_SEC_ENTRY: cmd_of = CMD_SEC_ENTRY;
         OP_SEC_EXIT, OP_PPB_STATUS: cmd_of = CMD_AUTOSEL;
         OP_PW_PROG: cmd_of = CMD_PW_PROG;
         OP_PW_VERIFY: cmd_of = CMD_PW_VERIFY;
         OP_PW_UNLOCK: cmd_of = CMD_PW_UNLOCK;
         OP_LOCK_SET: cmd_of = CMD_LOCK_SET;
         OP_LOCK_STATUS, OP_DYB_STATUS: cmd_of = CMD_LOCK_STATUS;
         OP_DYB_WRITE, OP_DYB_ERASE: cmd_of = CMD_BIT_VERIFY;
         OP_PROGRAM: cmd_of = CMD_PROGRAM;
         OP_SECT_ERASE: cmd_of = CMD_ERASE;
         default: cmd_of = CMD_LOCK;
      endcase
   endfunction

   // low address byte of the addressed protection bit
   function automatic logic [7:0] low_of(op_type op);
      case (op)
         OP_SEC_PROT_PROG, OP_SEC_PROT_STATUS: low_of = LOW_SECURE;
         OP_PPB_PROG, OP_PPB_STATUS, OP_PPB_ERASE_ALL: low_of = LOW_PPB;
         OP_PWLOCK_PROG, OP_PWLOCK_STATUS: low_of = LOW_PW_LOCK;
         OP_PERSLOCK_PROG, OP_PERSLOCK_STATUS: low_of = LOW_PERS_LOCK;
         default: low_of = 8'h00;
      endcase
   endfunction

   function automatic logic is_lock_prog(op_type op);
      return op == OP_SEC_PROT_PROG || op == OP_PPB_PROG || op == OP_PWLOCK_PROG || op == OP_PERSLOCK_PROG;
   endfunction

   function automatic step_type mk(step_kind_type k, logic [ADDR_W-1:0] a, logic [DQ_W-1:0] d);
      step_type s;
      s.kind = k;
      s.addr = a;
      s.data = d;
      return s;
   endfunction

   // one bus step of the chosen sequence
   function automatic step_type step_desc(op_type op, logic [3:0] st, logic [2:0] bank,
                                          logic [ADDR_W-1:0] tgt, logic [ADDR_W-1:0] sect,
                                          logic [DQ_W-1:0] dat, logic [DQ_W-1:0] pw);
      logic [ADDR_W-1:0] u1;
      logic [ADDR_W-1:0] u2;
      step_type d;
      u1 = {bank, 8'h00, ADDR_UNLOCK1};
      u2 = {bank, 8'h00, ADDR_UNLOCK2};
      d = mk(SK_END, tgt, 16'h0000);
      if (op == OP_RESET)
      begin
         if (st == 4'h0)
            d = mk(SK_WR, tgt, {8'h00, CMD_RESET});
      end
      else if (st == 4'h0)
         d = mk(SK_WR, u1, {8'h00, DATA_UNLOCK1});
      else if (st == 4'h1)
         d = mk(SK_WR, u2, {8'h00, DATA_UNLOCK2});
      else if (st == 4'h2)
         d = mk(SK_WR, u1, {8'h00, cmd_of(op)});
      else
      begin
         case (op)
            OP_SEC_EXIT:
               if (st == 4'h3)
                  d = mk(SK_WR, {bank, 20'h00000}, 16'h0000);
            OP_SEC_PROT_PROG, OP_PPB_PROG, OP_PWLOCK_PROG, OP_PERSLOCK_PROG:
               case (st)
                  4'h3: d = mk(SK_WR, tgt, {8'h00, CMD_PROG_BIT});
                  4'h4: d = mk(SK_WAIT_LOCK, tgt, 16'h0000);
                  4'h5: d = mk(SK_WR, tgt, {8'h00, CMD_BIT_VERIFY});
                  4'h6: d = mk(SK_RD, tgt, 16'h0000);
                  default: d = mk(SK_END, tgt, 16'h0000);
               endcase
            OP_SEC_PROT_STATUS, OP_PWLOCK_STATUS, OP_PERSLOCK_STATUS:
               case (st)
                  4'h3: d = mk(SK_WR, tgt, {8'h00, CMD_BIT_VERIFY});
                  4'h4: d = mk(SK_RD, tgt, 16'h0000);
                  default: d = mk(SK_END, tgt, 16'h0000);
               endcase
            OP_PPB_ERASE_ALL: // software programs every bit first
               case (st)
                  4'h3: d = mk(SK_WR, tgt, {8'h00, CMD_LOCK});
                  4'h4: d = mk(SK_WAIT_ERASE, tgt, 16'h0000);
                  4'h5: d = mk(SK_WR, sect, {8'h00, CMD_ERASE_BITS});
                  4'h6: d = mk(SK_RD, tgt, 16'h0000);
                  default: d = mk(SK_END, tgt, 16'h0000);
               endcase
            OP_PW_PROG:
               if (st == 4'h3)
                  d = mk(SK_WR, tgt, pw);
            OP_PW_VERIFY, OP_PPB_STATUS, OP_LOCK_STATUS, OP_DYB_STATUS:
               if (st == 4'h3)
                  d = mk(SK_RD, tgt, 16'h0000);
            OP_PW_UNLOCK:
               if (st <= 4'h9)
                  d = st[0] ? mk(SK_WR, tgt, pw) : mk(SK_WAIT_PW, tgt, 16'h0000);
            OP_DYB_WRITE, OP_DYB_ERASE:
               if (st == 4'h3)
                  d = mk(SK_WR, sect, {15'h0000, op == OP_DYB_WRITE});
            OP_PROGRAM:
               case (st)
                  4'h3: d = mk(SK_WR, tgt, dat);
                  4'h4: d = mk(SK_POLL, tgt, 16'h0000);
                  4'h5: d = mk(SK_RD, tgt, 16'h0000);
                  default: d = mk(SK_END, tgt, 16'h0000);
               endcase
            OP_SECT_ERASE:
               case (st)
                  4'h3: d = mk(SK_WR, u1, {8'h00, DATA_UNLOCK1});
                  4'h4: d = mk(SK_WR, u2, {8'h00, DATA_UNLOCK2});
                  4'h5: d = mk(SK_WR, sect, {8'h00, CMD_SECT_ERASE});
                  4'h6: d = mk(SK_POLL, sect, 16'h0000);
                  4'h7: d = mk(SK_RD, sect, 16'h0000);
                  default: d = mk(SK_END, tgt, 16'h0000);
               endcase
            default: d = mk(SK_END, tgt, 16'h0000);
         endcase
      end
      return d;
   endfunction

   state_type state_q;
   op_type op_q;
   logic [ADDR_W-1:0] addr_q;
   logic [DQ_W-1:0] data_q;
   logic [DQ_W-1:0] pw_q [0:3];
   logic [3:0] step_q;
   logic [3:0] retry_q;
   logic pass_q;
   logic fail_q;
   logic abort_q;
   logic aborted_q;
   logic [DQ_W-1:0] rd_q;
   logic req_q;
   logic tmr_load_q;
   logic [15:0] tmr_count_q;
   wire logic tmr_done;

   flash_cyc_if cyc_if ();
   assign cyc_if.req = req_q;

   // bus slave decode
   wire logic wb_hit = I_WB_CYC && I_WB_STB && !O_WB_ACK;
   wire logic wb_wr = wb_hit && I_WB_WE;
   wire logic busy = state_q != ST_IDLE;
   wire logic [31:0] ctrl_new = merge32({23'h0, 1'b0, 3'h0, op_q}, I_WB_DAT, I_WB_SEL);
   wire logic wr_ctrl = wb_wr && I_WB_ADR == REG_CTRL;
   wire logic start = wr_ctrl && ctrl_new[CTRL_GO_BIT] && !busy;
   wire logic [1:0] pw_sel = I_WB_ADR[3:2];
   wire logic wr_pw = wb_wr && I_WB_ADR[7:4] == REG_PW0[7:4] && I_WB_ADR[1:0] == 2'h0;
   wire logic [31:0] status_word = {rd_q, 10'h000, rd_q[1], rd_q[0], aborted_q, fail_q, pass_q, busy};
   wire logic [31:0] rd_mux =
      (I_WB_ADR == REG_CTRL) ? {27'h0, op_q} :
      (I_WB_ADR == REG_ADDR) ? {9'h000, addr_q} :
      (I_WB_ADR == REG_DATA) ? {16'h0000, data_q} :
      (I_WB_ADR == REG_STATUS) ? status_word :
      wr_pw || (I_WB_ADR[7:4] == REG_PW0[7:4] && I_WB_ADR[1:0] == 2'h0) ? {16'h0000, pw_q[pw_sel]} :
      32'h0000_0000;

   // sequence decode
   wire logic [1:0] pidx = (op_q == OP_PW_UNLOCK) ? step_q[2:1] - 2'h1 : addr_q[1:0];
   wire logic [2:0] bank = addr_q[22:20];
   wire logic [ADDR_W-1:0] sect = {addr_q[22:12], 12'h000};
   wire logic pw_op = op_q == OP_PW_PROG || op_q == OP_PW_VERIFY || op_q == OP_PW_UNLOCK;
   wire logic [ADDR_W-1:0] tgt =
      (op_q == OP_PROGRAM) ? addr_q :
      pw_op ? {bank, 18'h00000, pidx} :
      {addr_q[22:12], 4'h0, low_of(op_q)};
   wire step_type cur = step_desc(op_q, step_q, bank, tgt, sect, data_q, pw_q[pidx]);
   // program polls for the true bit seven, erase for one
   wire logic poll_want = (op_q == OP_PROGRAM) ? data_q[POLL_BIT] : 1'b1;
   wire logic verify_rd = is_lock_prog(op_q) || op_q == OP_PPB_ERASE_ALL;
   wire logic verify_ok = cyc_if.rdata[0] == is_lock_prog(op_q);
   wire logic [15:0] wait_cyc =
      (cur.kind == SK_WAIT_LOCK) ? 16'(LOCK_PROG_CYC) :
      (cur.kind == SK_WAIT_ERASE) ? 16'(PPB_ERASE_WAIT) : 16'(PW_GAP_CYC);

   gap_timer u_timer (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .i_load(tmr_load_q),
      .i_count(tmr_count_q),
      .o_done(tmr_done)
   );

   flash_cycle u_cycle (
      .i_clk(I_CLK),
      .i_rst_n(I_RST_N),
      .bus(cyc_if.cyc),
      .o_addr(O_FLASH_ADDR),
      .o_dq(O_FLASH_DQ),
      .o_dq_oe(O_FLASH_DQ_OE),
      .i_dq(I_FLASH_DQ),
      .o_cs_n(O_FLASH_CS_N),
      .o_oe_n(O_FLASH_OE_N),
      .o_we_n(O_FLASH_WE_N)
   );

   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N)
      begin
         O_WB_ACK <= 1'b0;
         O_WB_DAT <= 32'h0000_0000;
         op_q <= OP_RESET;
         addr_q <= '0;
         data_q <= '0;
         for (int i = 0; i < 4; i++)
            pw_q[i] <= '0;
      end
      else
      begin
         O_WB_ACK <= wb_hit;
         if (wb_hit)
            O_WB_DAT <= rd_mux;
         // operands are frozen while a sequence runs
         if (wr_ctrl && !busy)
            op_q <= op_type'(ctrl_new[4:0]);
         if (wb_wr && I_WB_ADR == REG_ADDR && !busy)
            addr_q <= ADDR_W'(merge32({9'h000, addr_q}, I_WB_DAT, I_WB_SEL));
         if (wb_wr && I_WB_ADR == REG_DATA && !busy)
            data_q <= DQ_W'(merge32({16'h0000, data_q}, I_WB_DAT, I_WB_SEL));
         if (wr_pw && !busy)
            pw_q[pw_sel] <= DQ_W'(merge32({16'h0000, pw_q[pw_sel]}, I_WB_DAT, I_WB_SEL));
      end
   end

   always_ff @(posedge I_CLK)
   begin
      if (!I_RST_N)
      begin
         state_q <= ST_IDLE;
         step_q <= 4'h0;
         retry_q <= 4'h0;
         pass_q <= 1'b0;
         fail_q <= 1'b0;
         abort_q <= 1'b0;
         aborted_q <= 1'b0;
         rd_q <= '0;
         req_q <= 1'b0;
         tmr_load_q <= 1'b0;
         tmr_count_q <= 16'h0000;
         cyc_if.we <= 1'b0;
         cyc_if.addr <= '0;
         cyc_if.wdata <= '0;
      end
      else
      begin
         req_q <= 1'b0;
         tmr_load_q <= 1'b0;
         if (wr_ctrl && ctrl_new[CTRL_ABORT_BIT] && busy)
            abort_q <= 1'b1;
         case (state_q)
            ST_IDLE:
            begin
               if (start)
               begin
                  state_q <= ST_EXEC;
                  step_q <= 4'h0;
                  retry_q <= 4'h0;
                  pass_q <= 1'b0;
                  fail_q <= 1'b0;
                  abort_q <= 1'b0;
                  aborted_q <= 1'b0;
               end
            end
            ST_EXEC:
            begin
               if (cur.kind == SK_END)
               begin
                  state_q <= ST_IDLE;
                  pass_q <= 1'b1;
               end
               else if (cur.kind == SK_WR || cur.kind == SK_RD || cur.kind == SK_POLL)
               begin
                  state_q <= ST_BUS;
                  req_q <= 1'b1;
                  cyc_if.we <= cur.kind == SK_WR;
                  cyc_if.addr <= cur.addr;
                  cyc_if.wdata <= cur.data;
               end
               else
               begin
                  state_q <= ST_WAIT;
                  tmr_load_q <= 1'b1;
                  tmr_count_q <= wait_cyc;
               end
            end
            ST_BUS:
            begin
               if (cyc_if.done)
               begin
                  state_q <= ST_EXEC;
                  if (cur.kind != SK_WR)
                     rd_q <= cyc_if.rdata;
                  if (cur.kind == SK_POLL)
                  begin
                     // status is read back right after the last write strobe
                     if (cyc_if.rdata[POLL_BIT] == poll_want)
                        step_q <= step_q + 4'h1;
                     else if (abort_q)
                     begin
                        state_q <= ST_IDLE;
                        aborted_q <= 1'b1;
                     end
                  end
                  else if (cur.kind == SK_RD && verify_rd && !verify_ok)
                  begin
                     // whole command reissued, bounded so a dead bit cannot hang us
                     if (retry_q == RETRY_MAX || abort_q)
                     begin
                        state_q <= ST_IDLE;
                        fail_q <= 1'b1;
                        aborted_q <= abort_q;
                     end
                     else
                     begin
                        retry_q <= retry_q + 4'h1;
                        step_q <= 4'h0;
                     end
                  end
                  else
                     step_q <= step_q + 4'h1;
               end
            end
            default:
            begin
               if (tmr_done)
               begin
                  state_q <= ST_EXEC;
                  step_q <= step_q + 4'h1;
               end
            end
         endcase
      end
   end
endmodule
`default_nettype wire

// ### rtl/gap_timer.sv
`timescale 1ns/1ps
`default_nettype none
module gap_timer
(
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_n,
   // control
   input wire logic i_load,
   input wire logic [15:0] i_count,
   output logic o_done
);
   logic [15:0] cnt_q;
   logic run_q;

   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         cnt_q <= 16'h0000;
         run_q <= 1'b0;
         o_done <= 1'b0;
      end
      else
      begin
         o_done <= 1'b0;
         if (i_load)
         begin
            cnt_q <= i_count;
            run_q <= 1'b1;
         end
         else if (run_q)
         begin
            cnt_q <= cnt_q - 16'h0001;
            if (cnt_q <= 16'h0001)
            begin
               run_q <= 1'b0;
               o_done <= 1'b1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ### test/flash_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model (
   input wire logic i_clk, i_cs_n, i_oe_n, i_we_n,
   input wire logic [15:0] i_dq,
   output logic [15:0] o_dq
);
   logic we_q = 1'b1, oe_q = 1'b1;
   logic [7:0] cmd_q = 8'h00;
   logic [15:0] word_q = 16'h0000, rd;
   logic [1:0] busy_q = 2'h0;
   assign rd = (busy_q != 2'h0) ? word_q ^ 16'h0080 : word_q;
   // released bus shows the inverse, so a stale sample cannot pass
   assign o_dq = (i_oe_n || i_cs_n) ? ~rd : rd;
   always_ff @(posedge i_clk)
   begin
      we_q <= i_we_n;
      oe_q <= i_oe_n;
      if (i_we_n && !we_q)
      begin
         cmd_q <= i_dq[7:0];
         // only the low byte decodes commands
         word_q <= (cmd_q != 8'hA0 && (i_dq[7:0] == 8'h48 || i_dq[7:0] == 8'h58)) ? 16'h0003 :
            (cmd_q != 8'hA0 && i_dq[7:0] == 8'h30) ? 16'hFFFF : i_dq;
         // short bounded busy also stands in for the sector-erase polls
         busy_q <= (cmd_q == 8'hA0 || i_dq[7:0] == 8'h30) ? 2'h2 : 2'h0;
      end
      else if (i_oe_n && !oe_q && busy_q != 2'h0)
         busy_q <= busy_q - 2'h1;
   end
endmodule
`default_nettype wire

// ### test/flash_protect_host_checker.sv
`timescale 1ns/1ps
`default_nettype none
module flash_protect_host_checker (
   input wire logic I_CLK, I_RST_N, I_WB_CYC, I_WB_STB, O_WB_ACK,
   input wire logic O_FLASH_DQ_OE, O_FLASH_CS_N, O_FLASH_OE_N, O_FLASH_WE_N,
   input wire logic [22:0] O_FLASH_ADDR
);
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RST_N);
   sequence s_wr_end;
      !O_FLASH_WE_N [*2] ##1 O_FLASH_WE_N ##1 O_FLASH_CS_N;
   endsequence
   sequence s_rd_end;
      !O_FLASH_OE_N [*5] ##1 O_FLASH_OE_N;
   endsequence
   AST_ACK_ANS: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK) else $error("ack late");
   AST_ACK_PULSE: assert property (O_WB_ACK |=> !O_WB_ACK) else $error("ack long");
   AST_WE_PULSE: assert property ($fell(O_FLASH_WE_N) |-> s_wr_end) else $error("strobe");
   AST_WE_DRIVE: assert property (!O_FLASH_WE_N |-> !O_FLASH_CS_N && O_FLASH_DQ_OE && O_FLASH_OE_N)
      else $error("write");
   AST_RD_FLOAT: assert property (!O_FLASH_OE_N |-> !O_FLASH_DQ_OE && !O_FLASH_CS_N) else $error("read");
   AST_OE_LEN: assert property ($fell(O_FLASH_OE_N) |-> s_rd_end) else $error("oe len");
   AST_ADDR_HOLD: assert property (!O_FLASH_CS_N && !$past(O_FLASH_CS_N) |-> $stable(O_FLASH_ADDR))
      else $error("addr moved");
   AST_IDLE_GAP: assert property ($rose(O_FLASH_CS_N) |=> O_FLASH_CS_N) else $error("gap");
endmodule
bind flash_protect_host flash_protect_host_checker chk (.*);
`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import flash_host_pkg::*;
   logic clk = 0, rst_n = 0, req = 0, we = 0, cs_n, oe_n, we_n, ack;
   logic [7:0] adr = 0;
   logic [31:0] wdat = 0, rdat, r;
   logic [15:0] fq, fdq, d;
   int n_mismatch = 0, total_checks = 0;
   flash_protect_host #(.PPB_ERASE_WAIT(40)) dut (.I_CLK(clk), .I_RST_N(rst_n), .I_WB_CYC(req), .I_WB_STB(req),
      .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hF), .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack),
      .O_FLASH_ADDR(), .O_FLASH_DQ(fq), .O_FLASH_DQ_OE(), .I_FLASH_DQ(fdq), .O_FLASH_CS_N(cs_n),
      .O_FLASH_OE_N(oe_n), .O_FLASH_WE_N(we_n));
   flash_dev_model dev (.i_clk(clk), .i_cs_n(cs_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_dq(fq), .o_dq(fdq));
   initial forever #12.5 clk = ~clk;
   task results;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
      int n = 0;
      @(posedge clk);
      req <= 1;
      we <= w;
      adr <= a;
      wdat <= v;
      do @(posedge clk); while (ack !== 1'b1 && ++n < 50);
      r = rdat;
      req <= 0;
      if (n >= 50)
      begin
         chk(0, 1);
         results();
      end
   endtask
   // status read once before polling: busy may lag the go write
   task automatic run(input logic [4:0] op, input logic [22:0] a, input logic [15:0] v);
      int n = 0;
      wb(1, REG_ADDR, 32'(a));
      wb(1, REG_DATA, 32'(v));
      wb(1, REG_CTRL, 32'h100 | 32'(op));
      wb(0, REG_STATUS, 0);
      do wb(0, REG_STATUS, 0); while (r[ST_BUSY_BIT] !== 1'b0 && ++n < 3000);
      if (n >= 3000)
      begin
         chk(0, 1);
         results();
      end
      $display("op %h done", op);
   endtask
   initial
   begin
      void'($urandom(5116));
      repeat (5) @(posedge clk);
      rst_n <= 1;
      wb(0, 8'h40, 32'hFFFF_FFFF);
      chk(r, 0);
      run(OP_RESET, 0, 0);
      chk(r[3:0], 4'h2);
      repeat (3)
      begin
         d = 16'($urandom) | 16'h0001;
         run(OP_PROGRAM, 23'($urandom), d);
         chk(r[31:16], d);
      end
      // every decoded op except OP_RESET runs once to completion
      for (int k = 1; k < 22; k++)
      begin
         run(5'(k), 23'($urandom), 16'($urandom));
         chk(r[2:1], 2'h1);
      end
      run(OP_SECT_ERASE, 23'h345000, 0);
      chk(r[31:16], 16'hFFFF);
      run(OP_PPB_PROG, 23'h1000, 0);
      chk(r[ST_PROT_BIT], 1);
      run(OP_LOCK_STATUS, 23'h2000, 0);
      chk(r[ST_LOCK_BIT], 1);
      run(OP_PPB_ERASE_ALL, 0, 0);
      chk(r[2:1], 2'h1);
      results();
   end
endmodule
`default_nettype wire
